// ---- htp_ctrl.v ----
// Hardware trigger playback controller: configuration registers, trigger
// arbitration, startup delay, playback and brake sequencing.
// Assumes an external wave engine that reports end of sequence and end of
// brake, and an upstream serial slave that drives the register port.
//
// Contract
// - A rising edge of a trigger starts playback only if its rise enable is 1; level mode starts regardless.
// - A rising edge plays the sequence in that trigger's 7-bit rise field.
// - A falling edge starts playback only if its fall enable is 1.
// - A falling edge plays the sequence in that trigger's 7-bit fall field.
// - The polarity bit makes low the active level when set.
// - The mode bit selects edge starts at 0 and level control at 1.
// - With brake enable set, braking follows the trigger's playback.
// - With boost enable set, boost is on during the trigger's playback.
// - Bit 3 of the second mode register enables one-wire mode.
// - The stop bit lets that trigger's playback end at once.
// - Playback waits the start delay count times one 48 kHz period.
// - A higher priority source may preempt a lower one, not the reverse.
// - The state field reads 1001 in playback, 1011 braking, 0000 idle.
`default_nettype none
`include "htp_defines.vh"

module htp_ctrl (
    input  wire       ref_clk_in,
    input  wire       reset_n_in,
    input  wire       ce_in,
    input  wire       hw_trigger_in_a,
    input  wire       hw_trigger_in_b,
    input  wire       hw_trigger_in_c,
    input  wire       soft_go_in,
    input  wire [6:0] soft_go_seq_in,
    input  wire       soft_stop_in,
    input  wire       seq_done_in,
    input  wire       brake_done_in,
    input  wire [7:0] reg_addr_in,
    input  wire       reg_wr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_rd_in,
    output reg  [7:0] reg_rdata_out,
    output wire       play_en_out,
    output wire [6:0] play_seq_out,
    output wire       boost_en_out,
    output wire       brake_en_out,
    output wire       single_line_mode_en_out,
    output wire [3:0] glb_state_out
);

    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_DELAY = 2'd1;
    localparam [1:0] ST_PLAY  = 2'd2;
    localparam [1:0] ST_BRAKE = 2'd3;
    localparam [1:0] SRC_GO   = 2'd3;
    localparam integer UNIT_CYC_I = `HTP_UNIT_CYC;
    localparam [10:0]  UNIT_CYC   = UNIT_CYC_I[10:0];

    reg  [7:0] rise_cfg_reg [0:2];
    reg  [7:0] fall_cfg_reg [0:2];
    reg  [7:0] mode_ab_reg;
    reg  [7:0] mode_c_reg;
    reg  [7:0] delay_reg;
    reg  [7:0] prio_reg;

    reg  [1:0]  state_reg;
    reg  [1:0]  owner_reg;
    reg  [6:0]  seq_reg;
    reg  [7:0]  unit_cnt_reg;
    reg  [10:0] tick_cnt_reg;

    wire [2:0] pin;
    wire [2:0] act_low;
    wire [2:0] lev_mode;
    wire [2:0] brk_en;
    wire [2:0] bst_en;
    wire [2:0] inst_stop;
    wire [2:0] act;
    wire [2:0] rise;
    wire [2:0] fall;
    reg  [3:0] req;
    reg  [6:0] req_seq [0:3];
    reg  [1:0] win;
    reg        win_valid;
    reg  [1:0] win_prio;
    integer    i;
    integer    j;
    integer    k;

    assign pin       = {hw_trigger_in_c, hw_trigger_in_b, hw_trigger_in_a};
    assign act_low   = {mode_c_reg[`HTP_MODE_C_LOW_BIT],
                        mode_ab_reg[`HTP_MODE_B_LOW_BIT],
                        mode_ab_reg[`HTP_MODE_A_LOW_BIT]};
    assign lev_mode  = {mode_c_reg[`HTP_MODE_C_LEV_BIT],
                        mode_ab_reg[`HTP_MODE_B_LEV_BIT],
                        mode_ab_reg[`HTP_MODE_A_LEV_BIT]};
    assign brk_en    = {mode_c_reg[`HTP_MODE_C_BRK_BIT],
                        mode_ab_reg[`HTP_MODE_B_BRK_BIT],
                        mode_ab_reg[`HTP_MODE_A_BRK_BIT]};
    assign bst_en    = {mode_c_reg[`HTP_MODE_C_BST_BIT],
                        mode_ab_reg[`HTP_MODE_B_BST_BIT],
                        mode_ab_reg[`HTP_MODE_A_BST_BIT]};
    assign inst_stop = {mode_c_reg[`HTP_STOP_C_BIT],
                        mode_c_reg[`HTP_STOP_B_BIT],
                        mode_c_reg[`HTP_STOP_A_BIT]};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_trig
            htp_trig_cond u_cond (
                .ref_clk_in    (ref_clk_in),
                .reset_n_in    (reset_n_in),
                .ce_in         (ce_in),
                .pin_in        (pin[g]),
                .active_low_in (act_low[g]),
                .active_out    (act[g]),
                .rise_out      (rise[g]),
                .fall_out      (fall[g])
            );
        end
    endgenerate

    // Requests per source; level mode starts on entering the active level
    always @*
    begin
        for (i = 0; i < 3; i = i + 1)
        begin
            if (lev_mode[i])
            begin
                req[i]     = rise[i];
                req_seq[i] = rise_cfg_reg[i][`HTP_SEQ_MSB:`HTP_SEQ_LSB];
            end
            else if (rise[i])
            begin
                req[i]     = rise_cfg_reg[i][`HTP_EDGE_EN_BIT];
                req_seq[i] = rise_cfg_reg[i][`HTP_SEQ_MSB:`HTP_SEQ_LSB];
            end
            else
            begin
                req[i]     = fall[i] & fall_cfg_reg[i][`HTP_EDGE_EN_BIT];
                req_seq[i] = fall_cfg_reg[i][`HTP_SEQ_MSB:`HTP_SEQ_LSB];
            end
        end
        req[3]     = soft_go_in;
        req_seq[3] = soft_go_seq_in;
    end

    // Priority word is an argument so callers stay sensitive to writes
    function [1:0] prio_of;
        input [7:0] prio;
        input [1:0] src;
        begin
            prio_of = prio[{src, 1'b1} -: 2];
        end
    endfunction

    // Ties resolve in fixed order a, b, c, then software go
    always @*
    begin
        win       = 2'd0;
        win_valid = 1'b0;
        win_prio  = 2'd0;
        for (j = 0; j < 4; j = j + 1)
        begin
            if (req[j] &&
                (!win_valid || prio_of(prio_reg, j[1:0]) > win_prio))
            begin
                win       = j[1:0];
                win_valid = 1'b1;
                win_prio  = prio_of(prio_reg, j[1:0]);
            end
        end
    end

    wire preempt = win_valid &&
                   (state_reg == ST_IDLE ||
                    win_prio > prio_of(prio_reg, owner_reg));
    wire owner_trig = (owner_reg != SRC_GO);
    wire owner_brk  = owner_trig ? brk_en[owner_reg] : 1'b1;
    wire owner_stop = owner_trig ? inst_stop[owner_reg] : 1'b1;
    wire owner_lev  = owner_trig & lev_mode[owner_reg];
    wire owner_act  = owner_trig & act[owner_reg];
    // Immediate stop is always honoured for software go, for a trigger only where its stop bit permits it
    wire stop_now   = owner_stop &
                      (soft_stop_in | (owner_lev & ~owner_act));
    // Level mode keeps replaying while the pin stays active
    wire play_end   = seq_done_in & ~(owner_lev & owner_act);

    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_reg    <= ST_IDLE;
            owner_reg    <= 2'd0;
            seq_reg      <= 7'h00;
            unit_cnt_reg <= 8'h00;
            tick_cnt_reg <= 11'h000;
        end
        else if (ce_in)
        begin
            if (preempt)
            begin
                state_reg    <= ST_DELAY;
                owner_reg    <= win;
                seq_reg      <= req_seq[win];
                unit_cnt_reg <= delay_reg;
                tick_cnt_reg <= 11'h000;
            end
            else
            begin
                case (state_reg)
                    ST_DELAY:
                    begin
                        if (unit_cnt_reg == 8'h00)
                            state_reg <= ST_PLAY;
                        else if (tick_cnt_reg == UNIT_CYC - 11'h001)
                        begin
                            tick_cnt_reg <= 11'h000;
                            unit_cnt_reg <= unit_cnt_reg - 8'h01;
                        end
                        else
                            tick_cnt_reg <= tick_cnt_reg + 11'h001;
                    end
                    ST_PLAY:
                    begin
                        if (stop_now || play_end)
                            state_reg <= owner_brk ? ST_BRAKE : ST_IDLE;
                    end
                    ST_BRAKE:
                    begin
                        if (brake_done_in)
                            state_reg <= ST_IDLE;
                    end
                    default:
                        state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Register writes
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (k = 0; k < 3; k = k + 1)
            begin
                rise_cfg_reg[k] <= `HTP_EDGE_CFG_RST;
                fall_cfg_reg[k] <= `HTP_EDGE_CFG_RST;
            end
            mode_ab_reg <= `HTP_MODE_AB_RST;
            mode_c_reg  <= `HTP_MODE_C_RST;
            delay_reg   <= `HTP_DELAY_RST;
            prio_reg    <= `HTP_PRIO_RST;
        end
        else if (ce_in && reg_wr_in)
        begin
            case (reg_addr_in)
                `HTP_ADDR_RISE_A: rise_cfg_reg[0] <= reg_wdata_in;
                `HTP_ADDR_RISE_B: rise_cfg_reg[1] <= reg_wdata_in;
                `HTP_ADDR_RISE_C: rise_cfg_reg[2] <= reg_wdata_in;
                `HTP_ADDR_FALL_A: fall_cfg_reg[0] <= reg_wdata_in;
                `HTP_ADDR_FALL_B: fall_cfg_reg[1] <= reg_wdata_in;
                `HTP_ADDR_FALL_C: fall_cfg_reg[2] <= reg_wdata_in;
                `HTP_ADDR_MODE_AB: mode_ab_reg <= reg_wdata_in;
                `HTP_ADDR_MODE_C: mode_c_reg <= reg_wdata_in;
                `HTP_ADDR_DELAY: delay_reg <= reg_wdata_in;
                `HTP_ADDR_PRIO: prio_reg <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses read zero
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            reg_rdata_out <= 8'h00;
        else if (ce_in && reg_rd_in)
        begin
            case (reg_addr_in)
                `HTP_ADDR_RISE_A: reg_rdata_out <= rise_cfg_reg[0];
                `HTP_ADDR_RISE_B: reg_rdata_out <= rise_cfg_reg[1];
                `HTP_ADDR_RISE_C: reg_rdata_out <= rise_cfg_reg[2];
                `HTP_ADDR_FALL_A: reg_rdata_out <= fall_cfg_reg[0];
                `HTP_ADDR_FALL_B: reg_rdata_out <= fall_cfg_reg[1];
                `HTP_ADDR_FALL_C: reg_rdata_out <= fall_cfg_reg[2];
                `HTP_ADDR_MODE_AB: reg_rdata_out <= mode_ab_reg;
                `HTP_ADDR_MODE_C: reg_rdata_out <= mode_c_reg;
                `HTP_ADDR_DELAY: reg_rdata_out <= delay_reg;
                `HTP_ADDR_PRIO: reg_rdata_out <= prio_reg;
                `HTP_ADDR_STATE: reg_rdata_out <= {4'h0, glb_state_out};
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    assign play_en_out  = (state_reg == ST_PLAY);
    assign play_seq_out = seq_reg;
    assign boost_en_out = (state_reg == ST_PLAY) &
                          (owner_trig ? bst_en[owner_reg] : 1'b1);
    assign brake_en_out = (state_reg == ST_BRAKE);
    assign single_line_mode_en_out = mode_c_reg[`HTP_ONEWIRE_BIT];
    assign glb_state_out = (state_reg == ST_BRAKE) ? `HTP_STATE_BRAKE :
                           (state_reg == ST_IDLE)  ? `HTP_STATE_STANDBY :
                                                     `HTP_STATE_TRIG;

endmodule

`default_nettype wire

// ---- htp_ctrl_asserts.sv ----
// Port checks of the trigger playback controller.
// Assumes one core clock; bound to htp_ctrl from the bench top file.
`default_nettype none
module htp_ctrl_asserts (
    input wire logic       ref_clk_in,
    input wire logic       reset_n_in,
    input wire logic       ce_in,
    input wire logic       brake_done_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       play_en_out,
    input wire logic       boost_en_out,
    input wire logic       brake_en_out,
    input wire logic       single_line_mode_en_out,
    input wire logic [3:0] glb_state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_rd_state;
        ce_in && reg_rd_in && reg_addr_in == 8'h3f;
    endsequence
    sequence s_wr_mode_c;
        ce_in && reg_wr_in && reg_addr_in == 8'h3a;
    endsequence
    chk_play_state: assert property (
        play_en_out |-> glb_state_out == 4'h9)
        else $error("play outside playback state");
    chk_brake_state: assert property (
        brake_en_out |-> glb_state_out == 4'hb)
        else $error("brake outside brake state");
    chk_idle_quiet: assert property (
        glb_state_out == 4'h0 |-> !(play_en_out || brake_en_out))
        else $error("activity while idle");
    chk_boost_play: assert property (
        boost_en_out |-> play_en_out)
        else $error("boost without playback");
    chk_brake_entry: assert property (
        $rose(brake_en_out) |-> $past(play_en_out))
        else $error("brake not after playback");
    chk_brake_end: assert property (
        ce_in && brake_en_out && brake_done_in |=> !brake_en_out)
        else $error("brake outlives its end");
    chk_start_delay: assert property (
        $rose(play_en_out) |-> $past(glb_state_out) == 4'h9)
        else $error("playback without start delay");
    chk_onewire_bit: assert property (
        s_wr_mode_c |=> single_line_mode_en_out == $past(reg_wdata_in[3]))
        else $error("one-wire bit not stored");
    chk_read_state: assert property (
        s_rd_state |=> reg_rdata_out == {4'h0, $past(glb_state_out)})
        else $error("state read mismatch");
endmodule
`default_nettype wire

// ---- htp_ctrl_test.sv ----
// Bench of the trigger playback controller: registers, edge and level
// starts, polarity, stop, start delay and priority.
// Assumes htp_host_model for pins and engine; checker bound at the foot.
`default_nettype none
`include "htp_defines.vh"
module htp_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n, wr, rd, stop, ce, go;
    logic [6:0] go_seq;
    logic [7:0] addr, wdata;
    wire logic [7:0] rdata;
    wire logic [6:0] seq;
    wire logic [3:0] glb;
    wire logic ta, tb_, tc, sdone, bdone, play, boost, brk, onew;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    htp_ctrl DUT (
        .ref_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce),
        .hw_trigger_in_a(ta), .hw_trigger_in_b(tb_), .hw_trigger_in_c(tc),
        .soft_go_in(go), .soft_go_seq_in(go_seq), .soft_stop_in(stop),
        .seq_done_in(sdone), .brake_done_in(bdone), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .play_en_out(play), .play_seq_out(seq),
        .boost_en_out(boost), .brake_en_out(brk),
        .single_line_mode_en_out(onew), .glb_state_out(glb));
    htp_host_model host (
        .ref_clk_in(clk), .play_en_in(play), .brake_en_in(brk),
        .trig_a_out(ta), .trig_b_out(tb_), .trig_c_out(tc),
        .seq_done_out(sdone), .brake_done_out(bdone));
    always #10 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata), 16'(e));
    endtask
    // Bounded wait on the state field (p=0) or on play enable (p=1)
    task automatic wait_on(input bit p, input logic [3:0] v, output int n);
        n = 0;
        while ((p ? {3'h0, play} : glb) !== v && n < 3000)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // Long enough for the pin filter to settle on the new level
    task automatic pin(input int i, input logic l);
        host.set_pin(i, l);
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic pulse_stop();
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        #1;
    endtask
    task automatic pulse_go(input logic [6:0] s);
        @(posedge clk);
        go <= 1'b1;
        go_seq <= s;
        @(posedge clk);
        go <= 1'b0;
        #1;
    endtask
    task automatic play_cycle(input int i, input logic l, input logic [6:0] s,
                              input logic bs, input logic bk);
        int n;
        host.set_pin(i, l);
        wait_on(0, 4'h9, n);
        chk(16'(seq), 16'(s));
        wait_on(1, 4'h1, n);
        chk(16'(boost), 16'(bs));
        wait_on(1, 4'h0, n);
        chk(16'(brk), 16'(bk));
        wait_on(0, 4'h0, n);
        chk(16'(n < 20), 16'h1);
    endtask
    task automatic t_regs();
        logic [7:0] e [13] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
            8'h33, 8'h30, 8'h00, 8'h01, 8'h00, 8'h1b, 8'h00};
        for (int i = 0; i < 13; i++)
            rdc(8'h33 + 8'(i), e[i]);
        wrr(`HTP_ADDR_STATE, 8'hff);
        rdc(`HTP_ADDR_STATE, 8'h00);
        wrr(`HTP_ADDR_FALL_C, 8'ha5);
        rdc(`HTP_ADDR_FALL_C, 8'ha5);
        wrr(`HTP_ADDR_FALL_C, 8'h01);
        // A write while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        wrr(`HTP_ADDR_DELAY, 8'h77);
        ce <= 1'b1;
        rdc(`HTP_ADDR_DELAY, 8'h01);
        $display("test regs done");
    endtask
    task automatic t_edges();
        wrr(`HTP_ADDR_DELAY, 8'h00);
        pin(0, 1'b1);
        chk(16'(glb), 16'h0);
        pin(0, 1'b0);
        wrr(`HTP_ADDR_RISE_A, 8'h95);
        play_cycle(0, 1'b1, 7'h15, 1'b1, 1'b1);
        pin(0, 1'b0);
        chk(16'(glb), 16'h0);
        wrr(`HTP_ADDR_FALL_B, 8'haa);
        pin(1, 1'b1);
        chk(16'(glb), 16'h0);
        play_cycle(1, 1'b0, 7'h2a, 1'b1, 1'b1);
        $display("test edges done");
    endtask
    task automatic t_pol();
        chk(16'(onew), 16'h0);
        wrr(`HTP_ADDR_MODE_C, 8'h88);
        #1 chk(16'(onew), 16'h1);
        wrr(`HTP_ADDR_RISE_C, 8'hb3);
        pin(2, 1'b1);
        chk(16'(glb), 16'h0);
        play_cycle(2, 1'b0, 7'h33, 1'b0, 1'b0);
        wrr(`HTP_ADDR_MODE_C, 8'h30);
        $display("test polarity done");
    endtask
    task automatic t_delay();
        int n [3];
        int k;
        for (int d = 0; d < 3; d++)
        begin
            wrr(`HTP_ADDR_DELAY, 8'(d));
            host.set_pin(0, 1'b1);
            wait_on(0, 4'h9, k);
            wait_on(1, 4'h1, n[d]);
            wait_on(0, 4'h0, k);
            pin(0, 1'b0);
        end
        chk(16'(n[0]), 16'h1);
        chk(16'(n[2] - n[1]), 16'h412);
        $display("test delay done");
    endtask
    task automatic t_lev();
        int n;
        host.play_len = 5000;
        wrr(`HTP_ADDR_DELAY, 8'h00);
        wrr(`HTP_ADDR_MODE_AB, 8'h43);
        wrr(`HTP_ADDR_MODE_C, 8'h34);
        host.set_pin(0, 1'b1);
        wait_on(1, 4'h1, n);
        chk(16'(seq), 16'h15);
        host.set_pin(0, 1'b0);
        wait_on(1, 4'h0, n);
        chk(16'(n < 8), 16'h1);
        chk(16'(glb), 16'h0);
        wrr(`HTP_ADDR_MODE_AB, 8'h33);
        host.set_pin(0, 1'b1);
        wait_on(1, 4'h1, n);
        pulse_stop();
        wait_on(1, 4'h0, n);
        chk(16'(n < 3), 16'h1);
        wait_on(0, 4'h0, n);
        pin(0, 1'b0);
        wrr(`HTP_ADDR_MODE_C, 8'h30);
        host.set_pin(0, 1'b1);
        wait_on(1, 4'h1, n);
        pulse_stop();
        repeat (8) @(posedge clk);
        #1 chk(16'(play), 16'h1);
        host.play_len = 20;
        wait_on(0, 4'h0, n);
        pin(0, 1'b0);
        $display("test level and stop done");
    endtask
    task automatic t_prio();
        int n;
        host.play_len = 5000;
        wrr(`HTP_ADDR_RISE_B, 8'hc4);
        host.set_pin(2, 1'b1);
        wait_on(1, 4'h1, n);
        chk(16'(seq), 16'h33);
        pin(0, 1'b1);
        chk(16'(seq), 16'h15);
        pin(1, 1'b1);
        chk(16'(seq), 16'h15);
        // Software go at its default lowest priority must not preempt
        pulse_go(7'h5a);
        repeat (4) @(posedge clk);
        #1 chk(16'(seq), 16'h15);
        wrr(`HTP_ADDR_PRIO, 8'hda);
        pulse_go(7'h5a);
        wait_on(1, 4'h1, n);
        chk(16'(seq), 16'h5a);
        chk(16'(boost), 16'h1);
        pulse_stop();
        wait_on(1, 4'h0, n);
        chk(16'(brk), 16'h1);
        host.play_len = 20;
        wait_on(0, 4'h0, n);
        chk(16'(glb), 16'h0);
        $display("test priority done");
    endtask
    task automatic results();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        stop = 1'b0;
        ce = 1'b1;
        go = 1'b0;
        go_seq = 7'h00;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_edges();
        t_pol();
        t_delay();
        t_lev();
        t_prio();
        results();
    end
endmodule
bind htp_ctrl htp_ctrl_asserts chk_i (
    .ref_clk_in, .reset_n_in, .ce_in, .brake_done_in, .reg_addr_in,
    .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .play_en_out,
    .boost_en_out, .brake_en_out, .single_line_mode_en_out, .glb_state_out);
`default_nettype wire

// ---- htp_defines.vh ----
// Register map, field positions, reset values and timing counts of the
// hardware trigger playback controller.
// Assumes a 50 MHz core clock and an 8-bit internal register port.
`ifndef HTP_DEFINES_VH
`define HTP_DEFINES_VH

`define HTP_ADDR_RISE_A     8'h33
`define HTP_ADDR_RISE_B     8'h34
`define HTP_ADDR_RISE_C     8'h35
`define HTP_ADDR_FALL_A     8'h36
`define HTP_ADDR_FALL_B     8'h37
`define HTP_ADDR_FALL_C     8'h38
`define HTP_ADDR_MODE_AB    8'h39
`define HTP_ADDR_MODE_C     8'h3a
`define HTP_ADDR_DELAY      8'h3c
`define HTP_ADDR_PRIO       8'h3e
`define HTP_ADDR_STATE      8'h3f

`define HTP_EDGE_EN_BIT     7
`define HTP_SEQ_MSB         6
`define HTP_SEQ_LSB         0

`define HTP_MODE_A_LOW_BIT  7
`define HTP_MODE_A_LEV_BIT  6
`define HTP_MODE_A_BRK_BIT  5
`define HTP_MODE_A_BST_BIT  4
`define HTP_MODE_B_LOW_BIT  3
`define HTP_MODE_B_LEV_BIT  2
`define HTP_MODE_B_BRK_BIT  1
`define HTP_MODE_B_BST_BIT  0
`define HTP_MODE_C_LOW_BIT  7
`define HTP_MODE_C_LEV_BIT  6
`define HTP_MODE_C_BRK_BIT  5
`define HTP_MODE_C_BST_BIT  4
`define HTP_ONEWIRE_BIT     3
`define HTP_STOP_A_BIT      2
`define HTP_STOP_B_BIT      1
`define HTP_STOP_C_BIT      0

`define HTP_EDGE_CFG_RST    8'h01
`define HTP_MODE_AB_RST     8'h33
`define HTP_MODE_C_RST      8'h30
`define HTP_DELAY_RST       8'h01
`define HTP_PRIO_RST        8'h1b

`define HTP_STATE_STANDBY   4'h0
`define HTP_STATE_TRIG      4'h9
`define HTP_STATE_BRAKE     4'hb

`define HTP_CLK_HZ          50000000
`define HTP_UNIT_HZ         48000
`define HTP_UNIT_CYC        ((`HTP_CLK_HZ + `HTP_UNIT_HZ - 1) / `HTP_UNIT_HZ)

`endif

// ---- htp_host_model.sv ----
// Host and wave engine stand-in: drives the three trigger pins, ends
// playback with a done level held until play drops, and brake with a one-cycle done pulse.
// Assumes the controller's core clock; pins change just after an edge.
`default_nettype none
module htp_host_model (
    input  wire logic ref_clk_in,
    input  wire logic play_en_in,
    input  wire logic brake_en_in,
    output wire logic trig_a_out,
    output wire logic trig_b_out,
    output wire logic trig_c_out,
    output wire logic seq_done_out,
    output wire logic brake_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lowering play_len mid-play raises done on the next edge and ends a long playback one edge later
    int play_len = 20;
    int play_cnt = 0;
    int brk_cnt = 0;
    logic [2:0] pins = 3'h0;
    logic seq_done_q = 1'b0;
    logic brake_done_q = 1'b0;
    assign trig_a_out = pins[0];
    assign trig_b_out = pins[1];
    assign trig_c_out = pins[2];
    assign seq_done_out = seq_done_q;
    assign brake_done_out = brake_done_q;
    always @(posedge ref_clk_in)
    begin
        play_cnt <= play_en_in ? play_cnt + 1 : 0;
        brk_cnt <= brake_en_in ? brk_cnt + 1 : 0;
        seq_done_q <= play_en_in && play_cnt >= play_len - 1;
        brake_done_q <= brake_en_in && brk_cnt == 4;
    end
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge ref_clk_in);
        pins[idx] <= lvl;
    endtask
endmodule
`default_nettype wire

// ---- htp_trig_cond.v ----
// One trigger pin conditioner: three-stage synchroniser, agreement filter,
// polarity and edge detection.
// Assumes an asynchronous pin and a single core clock with clock enable.
`default_nettype none

module htp_trig_cond (
    input  wire ref_clk_in,
    input  wire reset_n_in,
    input  wire ce_in,
    input  wire pin_in,
    input  wire active_low_in,
    output wire active_out,
    output wire rise_out,
    output wire fall_out
);

    reg  sync1_reg;
    reg  sync2_reg;
    reg  sync3_reg;
    reg  filt_reg;
    reg  prev_reg;
    wire act_now;

    assign act_now = filt_reg ^ active_low_in;

    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            filt_reg  <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else if (ce_in)
        begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            // Accept a change only once the later two stages agree
            if (sync2_reg == sync3_reg)
                filt_reg <= sync3_reg;
            prev_reg <= act_now;
        end
    end

    assign active_out = act_now;
    assign rise_out   = act_now & ~prev_reg;
    assign fall_out   = ~act_now & prev_reg;

endmodule

`default_nettype wire
